// [hdl/sio_defs.vh]
`ifndef SIO_DEFS_VH
`define SIO_DEFS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define SIO_A_IN_ALLOC_LO  12'h000
`define SIO_A_IN_ALLOC_HI  12'h004
`define SIO_A_OUT_SEL      12'h008
`define SIO_A_BUS_EN_LO    12'h00C
`define SIO_A_BUS_EN_HI    12'h010
`define SIO_A_FILTER       12'h014
`define SIO_A_INV_LO       12'h018
`define SIO_A_INV_HI       12'h01C
`define SIO_A_REGEN        12'h020
`define SIO_A_OVL_TH       12'h024
`define SIO_A_OVH_TH       12'h028
`define SIO_A_OUT_INV      12'h02C
`define SIO_A_TRQ_TH       12'h030
`define SIO_A_BUS_VAL      12'h034
`define SIO_A_STATUS       12'h038
`define SIO_A_INT_STAT     12'h03C
`define SIO_A_INT_MASK     12'h040
`define SIO_A_FUNC         12'h044
// ****************************************
// Reset values
// ****************************************
`define SIO_RST_IN_LO      16'h3210
`define SIO_RST_IN_HI      16'h7654
`define SIO_RST_OUT_SEL    16'h0210
`define SIO_RST_OUT_LIVE   12'h210
`define SIO_RST_FILTER     16'h0002
`define SIO_RST_OVL_TH     16'h0064
`define SIO_RST_OVH_TH     16'h0064
`define SIO_RST_TRQ_TH     16'h0064
// ****************************************
// Timing: one filter step is 1 us
// ****************************************
`define SIO_CLK_MHZ        100
`define SIO_TICK_NS        1000
`define SIO_TICK_CYC       ((`SIO_TICK_NS * `SIO_CLK_MHZ) / 1000)
`endif

// [hdl/sio_alloc.v]
`timescale 1ns/1ps
`include "sio_defs.vh"
module sio_alloc (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  in_pin,
  input  wire [9:0]  status_src,
  input  wire [15:0] load_pct,
  input  wire [15:0] winding_temp,
  input  wire [15:0] torque_pct,
  output reg  [14:0] func_out,
  output reg  [3:0]  out_pin,
  output reg         overload_alarm,
  output reg         motor_overheat_alarm,
  output reg         regen_internal,
  output reg         irq
);
  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] in_alloc_q;
  reg [15:0] out_sel_q;
  reg        sel_wr_q;
  reg        restart_q;
  reg [11:0] out_sel_live_q;
  reg [3:0]  bus_en_lo_q;
  reg [3:0]  bus_en_hi_q;
  reg [15:0] filter_q;
  reg [3:0]  inv_lo_q;
  reg [3:0]  inv_hi_q;
  reg        regen_q;
  reg [15:0] ovl_th_q;
  reg [15:0] ovh_th_q;
  reg [3:0]  out_inv_q;
  reg [15:0] trq_th_q;
  reg [7:0]  bus_val_q;
  reg [2:0]  int_stat_q;
  reg [2:0]  int_mask_q;
  reg [7:0]  sync1_q;
  reg [7:0]  sync2_q;
  wire [7:0] filt_seen;
  reg [15:0] tick_cnt_q;
  reg        tick_q;
  reg        torque_det_q;
  reg [31:0] rd_d;

  wire       wr_en = psel & penable & pwrite;
  wire [7:0] bus_en = {bus_en_hi_q, bus_en_lo_q};
  wire [7:0] inv    = {inv_hi_q, inv_lo_q};
  wire       ovl_hit = load_pct > ovl_th_q;
  wire       ovh_hit = winding_temp > ovh_th_q;
  wire       trq_hit = torque_pct > trq_th_q;
  wire [7:0] port_val;
  wire [9:0] stat_all = {torque_det_q, status_src[8:0]};

  // ****************************************
  // Pin synchroniser and filter
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q    <= 8'h00;
      sync2_q    <= 8'h00;
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      sync1_q <= in_pin;
      sync2_q <= sync1_q;
      tick_q  <= (tick_cnt_q == `SIO_TICK_CYC - 1);
      if (tick_cnt_q == `SIO_TICK_CYC - 1)
        tick_cnt_q <= 16'h0000;
      else
        tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_port
      reg [15:0] cnt_q;
      reg        filt_bit_q;
      // A change must hold for the filter time before it is seen
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q      <= 16'h0000;
          filt_bit_q <= 1'b0;
        end else if (sync2_q[g] == filt_bit_q) begin
          cnt_q <= 16'h0000;
        end else if (cnt_q >= filter_q) begin
          filt_bit_q <= sync2_q[g];
          cnt_q      <= 16'h0000;
        end else if (tick_q) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
      assign filt_seen[g] = filt_bit_q;
      // Bus value replaces the pin, then inversion applies to either
      assign port_val[g] = bus_en[g] ? (bus_val_q[g] ^ inv[g])
                                     : (filt_bit_q ^ inv[g]);
    end
  endgenerate

  // ****************************************
  // Function routing
  // ****************************************
  reg [14:0] func_d;
  reg        claimed;
  integer    p;
  integer    f;
  always @* begin
    func_d = 15'h0000;
    for (f = 0; f < 15; f = f + 1) begin
      claimed = 1'b0;
      // Port 0 (pin 14) is scanned first so it wins conflicts
      for (p = 0; p < 8; p = p + 1) begin
        if (!claimed && in_alloc_q[p*4 +: 4] == f[3:0]) begin
          func_d[f] = port_val[p];
          claimed   = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Output mapping; out_pin 0..3 = pairs 5/6, 7/8, 9/10, 11/12
  // ****************************************
  function sel_stat;
    input [3:0] d;
    input [9:0] s;
    begin
      sel_stat = (d < 4'hA) ? s[d] : 1'b0;
    end
  endfunction

  wire [3:0] out_d = {sel_stat(out_sel_live_q[3:0], stat_all),
                      sel_stat(out_sel_live_q[11:8], stat_all),
                      1'b0,
                      sel_stat(out_sel_live_q[7:4], stat_all)};

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  always @* begin
    case (paddr)
      `SIO_A_IN_ALLOC_LO: rd_d = {16'h0000, in_alloc_q[15:0]};
      `SIO_A_IN_ALLOC_HI: rd_d = {16'h0000, in_alloc_q[31:16]};
      `SIO_A_OUT_SEL:     rd_d = {16'h0000, sel_wr_q ? out_sel_q : {4'h0, out_sel_live_q}};
      `SIO_A_BUS_EN_LO:   rd_d = {28'h0000000, bus_en_lo_q};
      `SIO_A_BUS_EN_HI:   rd_d = {28'h0000000, bus_en_hi_q};
      `SIO_A_FILTER:      rd_d = {16'h0000, filter_q};
      `SIO_A_INV_LO:      rd_d = {28'h0000000, inv_lo_q};
      `SIO_A_INV_HI:      rd_d = {28'h0000000, inv_hi_q};
      `SIO_A_REGEN:       rd_d = {31'h00000000, regen_q};
      `SIO_A_OVL_TH:      rd_d = {16'h0000, ovl_th_q};
      `SIO_A_OVH_TH:      rd_d = {16'h0000, ovh_th_q};
      `SIO_A_OUT_INV:     rd_d = {28'h0000000, out_inv_q};
      `SIO_A_TRQ_TH:      rd_d = {16'h0000, trq_th_q};
      `SIO_A_BUS_VAL:     rd_d = {24'h000000, bus_val_q};
      `SIO_A_STATUS:      rd_d = {20'h00000, out_pin, filt_seen};
      `SIO_A_INT_STAT:    rd_d = {29'h00000000, int_stat_q};
      `SIO_A_INT_MASK:    rd_d = {29'h00000000, int_mask_q};
      `SIO_A_FUNC:        rd_d = {17'h00000, func_out};
      default:            rd_d = 32'h00000000;
    endcase
  end

  wire mapped = (paddr <= `SIO_A_FUNC) && (paddr[1:0] == 2'b00);

  // ****************************************
  // Write strobes, one per writable register except interrupt status, which is cleared through w1c
  // ****************************************
  wire wr_hit     = wr_en & pready;
  wire we_in_lo   = wr_hit & (paddr == `SIO_A_IN_ALLOC_LO);
  wire we_in_hi   = wr_hit & (paddr == `SIO_A_IN_ALLOC_HI);
  wire we_out_sel = wr_hit & (paddr == `SIO_A_OUT_SEL);
  wire we_ben_lo  = wr_hit & (paddr == `SIO_A_BUS_EN_LO);
  wire we_ben_hi  = wr_hit & (paddr == `SIO_A_BUS_EN_HI);
  wire we_filter  = wr_hit & (paddr == `SIO_A_FILTER);
  wire we_inv_lo  = wr_hit & (paddr == `SIO_A_INV_LO);
  wire we_inv_hi  = wr_hit & (paddr == `SIO_A_INV_HI);
  wire we_regen   = wr_hit & (paddr == `SIO_A_REGEN);
  wire we_ovl_th  = wr_hit & (paddr == `SIO_A_OVL_TH);
  wire we_ovh_th  = wr_hit & (paddr == `SIO_A_OVH_TH);
  wire we_out_inv = wr_hit & (paddr == `SIO_A_OUT_INV);
  wire we_trq_th  = wr_hit & (paddr == `SIO_A_TRQ_TH);
  wire we_bus_val = wr_hit & (paddr == `SIO_A_BUS_VAL);
  wire we_mask    = wr_hit & (paddr == `SIO_A_INT_MASK);

  // ****************************************
  // Handshake and read data
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_d;
    end
  end

  // ****************************************
  // Settings
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      in_alloc_q <= {`SIO_RST_IN_HI, `SIO_RST_IN_LO};
    else if (we_in_lo)
      in_alloc_q[15:0] <= pwdata[15:0];
    else if (we_in_hi)
      in_alloc_q[31:16] <= pwdata[15:0];
  end

  // Holds across presetn on purpose, so the restart can pick it up
  always @(posedge pclk) begin
    if (we_out_sel) begin
      out_sel_q <= pwdata[15:0];
      sel_wr_q  <= 1'b1;
    end
  end

  // Latched only by a restart, so live allocation changes cannot glitch pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sel_live_q <= `SIO_RST_OUT_LIVE;
      restart_q      <= 1'b1;
    end else begin
      restart_q <= 1'b0;
      if (restart_q && sel_wr_q)
        out_sel_live_q <= out_sel_q[11:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bus_en_lo_q <= 4'h0;
    else if (we_ben_lo)
      bus_en_lo_q <= pwdata[3:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bus_en_hi_q <= 4'h0;
    else if (we_ben_hi)
      bus_en_hi_q <= pwdata[3:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      filter_q <= `SIO_RST_FILTER;
    else if (we_filter)
      filter_q <= pwdata[15:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      inv_lo_q <= 4'h0;
    else if (we_inv_lo)
      inv_lo_q <= pwdata[3:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      inv_hi_q <= 4'h0;
    else if (we_inv_hi)
      inv_hi_q <= pwdata[3:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      regen_q <= 1'b0;
    else if (we_regen)
      regen_q <= pwdata[0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovl_th_q <= `SIO_RST_OVL_TH;
    else if (we_ovl_th)
      ovl_th_q <= pwdata[15:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovh_th_q <= `SIO_RST_OVH_TH;
    else if (we_ovh_th)
      ovh_th_q <= pwdata[15:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      out_inv_q <= 4'h0;
    else if (we_out_inv)
      out_inv_q <= pwdata[3:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trq_th_q <= `SIO_RST_TRQ_TH;
    else if (we_trq_th)
      trq_th_q <= pwdata[15:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bus_val_q <= 8'h00;
    else if (we_bus_val)
      bus_val_q <= pwdata[7:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      int_mask_q <= 3'h0;
    else if (we_mask)
      int_mask_q <= pwdata[2:0];
  end

  // ****************************************
  // Outputs, alarms and interrupts
  // ****************************************
  wire [2:0] ev = {trq_hit & ~torque_det_q,
                   ovh_hit & ~motor_overheat_alarm,
                   ovl_hit & ~overload_alarm};
  wire [2:0] w1c = (wr_en & pready & (paddr == `SIO_A_INT_STAT)) ? pwdata[2:0] : 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_out             <= 15'h0000;
      out_pin              <= 4'h0;
      overload_alarm       <= 1'b0;
      motor_overheat_alarm <= 1'b0;
      torque_det_q         <= 1'b0;
      regen_internal       <= 1'b0;
      int_stat_q           <= 3'h0;
      irq                  <= 1'b0;
    end else begin
      func_out             <= func_d;
      out_pin              <= out_d ^ out_inv_q;
      overload_alarm       <= ovl_hit;
      motor_overheat_alarm <= ovh_hit;
      torque_det_q         <= trq_hit;
      regen_internal       <= regen_q;
      int_stat_q           <= (int_stat_q & ~w1c) | ev;
      irq                  <= |(((int_stat_q & ~w1c) | ev) & int_mask_q);
    end
  end

  // Threshold range is not clamped; software keeps it below 120
endmodule

// [verification/sio_host.sv]
`timescale 1ns/1ps
// ****
// Host controller pins
// ****
module sio_host (
  input wire        pclk,
  output reg [7:0]  in_pin,
  output reg [9:0]  status_src,
  output reg [15:0] load_pct,
  output reg [15:0] winding_temp,
  output reg [15:0] torque_pct
);
  initial begin
    {in_pin, status_src, load_pct, winding_temp, torque_pct} = 66'h0;
  end
  task put(input [7:0] p, input [9:0] s, input [15:0] l, input [15:0] t, input [15:0] q);
    begin
      @(posedge pclk);
      in_pin       <= p;
      status_src   <= s;
      load_pct     <= l;
      winding_temp <= t;
      torque_pct   <= q;
    end
  endtask
endmodule

// [verification/sio_alloc_monitor.sv]
`timescale 1ns/1ps
module sio_mon (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  in_pin,
  input wire [9:0]  status_src,
  input wire [15:0] load_pct,
  input wire [15:0] winding_temp,
  input wire [15:0] torque_pct,
  input wire [14:0] func_out,
  input wire [3:0]  out_pin,
  input wire        overload_alarm,
  input wire        motor_overheat_alarm,
  input wire        regen_internal,
  input wire        irq
);
  // ****
  // Shadow of settings
  // ****
  reg [15:0] sh [0:17];
  reg        sel_seen = 1'b0;
  integer    k;
  wire       wr = psel & penable & pready & pwrite & ~pslverr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < 18; k = k + 1) sh[k] <= 16'h0000;
      sh[0]  <= 16'h3210;
      sh[1]  <= 16'h7654;
      sh[9]  <= 16'h0064;
      sh[10] <= 16'h0064;
    end else if (wr && paddr < 12'h048) begin
      sh[paddr[6:2]] <= pwdata[15:0];
    end
  end
  // Output select only reloads on restart, so routing checks stop once it is written
  always @(posedge pclk) begin
    if (wr && paddr == 12'h008) begin
      sel_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ovl_alarm: assert property ($past(presetn) |-> overload_alarm ==
    ($past(load_pct) > $past(sh[9]))) else $error("overload alarm mismatch");
  a_ovh_alarm: assert property ($past(presetn) |-> motor_overheat_alarm ==
    ($past(winding_temp) > $past(sh[10]))) else $error("overheat alarm mismatch");
  a_regen_path: assert property ($past(presetn) |-> regen_internal == $past(sh[8][0]))
    else $error("regen select mismatch");
  a_pair78_inv: assert property ($past(presetn) |-> out_pin[1] == $past(sh[11][1]))
    else $error("pair 7/8 level wrong");
  a_out_route: assert property ($past(presetn) && !sel_seen |->
    out_pin[3] == $past(status_src[0] ^ sh[11][3]) && out_pin[0] == $past(status_src[1]
    ^ sh[11][0]) && out_pin[2] == $past(status_src[2] ^ sh[11][2])) else $error("output route");
  a_bus_port: assert property ($past(presetn) && $past(sh[3][0]) && $past(sh[0][3:0]) == 4'h0
    |-> func_out[0] == $past(sh[13][0] ^ sh[6][0])) else $error("bus input value wrong");
  a_filter_hold: assert property ($changed(func_out[0]) && !$past(sh[3][0]) &&
    !$past(sh[6][0]) && $past(sh[0][3:0]) == 4'h0 |-> $past(in_pin[0], 2) == func_out[0])
    else $error("input seen before filter");
  a_func_range: assert property ($past(presetn) && $past(sh[0]) == 16'h3210 &&
    $past(sh[1]) == 16'h7654 |-> func_out[14:8] == 7'h00) else $error("unallocated function");
  c_ovl: cover property (overload_alarm);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule
bind sio_alloc sio_mon i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .in_pin, .status_src, .load_pct, .winding_temp, .torque_pct,
  .func_out, .out_pin, .overload_alarm, .motor_overheat_alarm, .regen_internal, .irq);

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  reg         pclk, presetn, psel, penable, pwrite, err, ia, ib;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [32:0] rows [0:3];
  wire [31:0] prdata;
  wire        pready, pslverr, ovl, ovh, regen_internal, irq;
  wire [7:0]  in_pin;
  wire [9:0]  status_src;
  wire [15:0] load_pct, winding_temp, torque_pct;
  wire [14:0] func_out;
  wire [3:0]  out_pin;
  integer     failures, n_compared, i;
  sio_alloc i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_pin, .status_src, .load_pct, .winding_temp, .torque_pct,
    .func_out, .out_pin, .overload_alarm(ovl), .motor_overheat_alarm(ovh), .regen_internal,
    .irq);
  sio_host i_host (.pclk, .in_pin, .status_src, .load_pct, .winding_temp, .torque_pct);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task print_verdict;
    begin
      $display("failures=%0d n_compared=%0d", failures, n_compared);
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #600000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, failures, n_compared} = 0;
    // Thresholds kept below 120
    rows[0] = {16'h0064, 16'h0064, 1'b0};
    rows[1] = {16'h0064, 16'h0065, 1'b1};
    rows[2] = {16'h0077, 16'h0076, 1'b0};
    rows[3] = {16'h0000, 16'h0001, 1'b1};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); check(rd, 32'h3210);
    apb(0, 12'h014, 0); check(rd, 32'h0002);
    apb(1, 12'h048, 1); check(err, 1'b1);
    apb(0, 12'h048, 0); check(rd, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 12'h024, rows[i][32:17]);
      apb(1, 12'h028, rows[i][32:17]);
      i_host.put(8'h00, 10'h000, rows[i][16:1], rows[i][16:1], 16'h0000);
      repeat (3) @(posedge pclk);
      check(ovl, rows[i][0]);
      check(ovh, rows[i][0]);
    end
    apb(1, 12'h040, 0); ia = irq;
    apb(1, 12'h040, 7); repeat (2) @(posedge pclk); ib = irq;
    check(ia ^ ib, 1'b1);
    apb(1, 12'h03C, 7);
    i_host.put(8'h00, 10'h000, 16'h0000, 16'h0000, 16'h0065);
    repeat (2) @(posedge pclk);
    apb(0, 12'h03C, 0); check(rd, 32'h4);
    apb(1, 12'h03C, 7); repeat (2) @(posedge pclk); check(irq, 1'b0);
    apb(1, 12'h020, 1); repeat (2) @(posedge pclk); check(regen_internal, 1'b1);
    i_host.put(8'h00, 10'h007, 16'h0000, 16'h0000, 16'h0065);
    repeat (3) @(posedge pclk); check(out_pin, 4'hD);
    apb(1, 12'h02C, 16'h000F); repeat (2) @(posedge pclk); check(out_pin, 4'h2);
    apb(1, 12'h02C, 0);
    i_host.put(8'h00, 10'h006, 16'h0000, 16'h0000, 16'h0065);
    apb(1, 12'h008, 16'h0009); repeat (2) @(posedge pclk); check(out_pin, 4'h5);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk); check(out_pin, 4'h8);
    i_host.put(8'h01, 10'h006, 16'h0000, 16'h0000, 16'h0000);
    repeat (50) @(posedge pclk); check(func_out, 15'h0000);
    check(out_pin, 4'h0);
    repeat (400) @(posedge pclk); check(func_out, 15'h0001);
    apb(1, 12'h018, 1); repeat (2) @(posedge pclk); check(func_out, 15'h0000);
    apb(1, 12'h034, 0); apb(1, 12'h00C, 1); repeat (2) @(posedge pclk);
    check(func_out, 15'h0001);
    apb(1, 12'h034, 1); repeat (2) @(posedge pclk); check(func_out, 15'h0000);
    apb(1, 12'h00C, 0); apb(1, 12'h018, 0); apb(1, 12'h014, 0);
    for (i = 0; i < 15; i = i + 1) begin
      apb(1, 12'h000, {12'h321, i[3:0]}); repeat (2) @(posedge pclk);
      check(func_out, 15'h0001 << i);
    end
    apb(1, 12'h000, 16'h3200);
    i_host.put(8'h02, 10'h000, 16'h0000, 16'h0000, 16'h0000);
    repeat (10) @(posedge pclk); check(func_out, 15'h0000);
    print_verdict;
  end
endmodule
